// [bench/host_model.sv]
// host side of the card bus: link clock, command and data lines
// assumes pull-ups on both lines; the link clock stands still between transfers
`timescale 1ns/1ps
module host_model
  import card_link_pkg::*;
(
  // time base
  input  wire logic clock,
  // card drive
  input  wire logic cmd_out,
  input  wire logic cmd_oe,
  input  wire logic dat_out,
  input  wire logic dat_oe,
  // resolved bus
  output logic      link_clk,
  output logic      cmd_line,
  output logic      dat_line
);
  logic        h_coe = 1'b0;
  logic        h_c   = 1'b1;
  logic        h_doe = 1'b0;
  logic        h_d   = 1'b1;
  logic [63:0] rcv;
  logic [63:0] rdv;
  event        got_c;
  event        got_d;

  initial link_clk = 1'b1;
  // released lines go to the pull-up level
  assign cmd_line = cmd_oe ? cmd_out : (h_coe ? h_c : 1'b1);
  assign dat_line = dat_oe ? dat_out : (h_doe ? h_d : 1'b1);

  // data changes with the falling edge, the card samples on the rise
  task automatic tick(input int n);
    repeat (n)
    begin
      link_clk <= ~link_clk;
      repeat (4) @(negedge clock);
      link_clk <= ~link_clk;
      repeat (4) @(negedge clock);
    end
  endtask

  function automatic logic [6:0] crc7(input logic [39:0] m);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? CRC7_POLY : 7'h00);
    return c;
  endfunction

  function automatic logic [15:0] crc16(input logic [31:0] m);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 31; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((m[i] ^ c[15]) ? CRC16_POLY : 16'h0000);
    return c;
  endfunction

  task automatic send(input logic sel, input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      if (sel)
        {h_doe, h_d} = {1'b1, v[i]};
      else
        {h_coe, h_c} = {1'b1, v[i]};
      tick(1);
    end
    {h_coe, h_doe} = 2'b00;
  endtask

  task automatic ones(input int n);
    send(1'b0, 64'hFFFF_FFFF_FFFF_FFFF, n);
  endtask

  task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic good);
    logic [39:0] f;
    f = {2'b01, idx, arg};
    // a bad frame flips the lowest checksum bit
    send(1'b0, {16'h0000, f, crc7(f) ^ {6'h00, ~good}, 1'b1}, 48);
  endtask

  // sampled at the fall: the card only moves its lines a few clocks later
  task automatic rx(input logic sel, input int n);
    logic [63:0] v;
    logic        found;
    v = '1;
    found = 1'b0;
    for (int i = 0; i < 60 && !found; i++)
    begin
      @(negedge link_clk);
      found = ((sel ? dat_line : cmd_line) === 1'b0);
    end
    if (found)
    begin
      v = 64'h0;
      repeat (n - 1)
      begin
        @(negedge link_clk);
        v = {v[62:0], (sel ? dat_line : cmd_line)};
      end
    end
    if (sel)
    begin
      rdv = v;
      ->got_d;
    end
    else
    begin
      rcv = v;
      ->got_c;
    end
  endtask
endmodule

// [bench/tb.sv]
// self-checking bench for the card link core
// assumes host_model on the far side and a 20 MHz core clock
`timescale 1ns/1ps
module tb
  import card_link_pkg::*;
;
  localparam int          NB   = 4;
  localparam logic [23:0] VP   = 24'hFF8000;  // the core's default profile
  localparam logic [63:0] NONE = '1;
  logic        clock;
  logic        nrst;
  logic        link_clk;
  logic        cmd_line;
  logic        dat_line;
  logic        cmd_out;
  logic        cmd_oe;
  logic        dat_out;
  logic        dat_oe;
  logic        rd_take;
  logic        wr_valid;
  logic        wr_done;
  logic        wr_crc_ok;
  logic        init_done;
  logic        card_active;
  logic [7:0]  rd_data;
  logic [7:0]  wr_data;
  logic [7:0]  rb[NB];
  logic [63:0] cq[$];
  logic [63:0] dq[$];
  logic [63:0] wq[$];
  int          mismatches;
  int          samples_checked;
  int          ri;

  card_link_core #(.BLOCK_BYTES(NB), .POWERUP_CYCLES(1000)) dut (
    .clock(clock), .nrst(nrst), .link_clk(link_clk), .cmd_in(cmd_line), .cmd_out(cmd_out),
    .cmd_oe(cmd_oe), .dat_in(dat_line), .dat_out(dat_out), .dat_oe(dat_oe), .rd_data(rd_data),
    .rd_take(rd_take), .wr_data(wr_data), .wr_valid(wr_valid), .wr_done(wr_done),
    .wr_crc_ok(wr_crc_ok), .init_done(init_done), .card_active(card_active));

  host_model h (
    .clock(clock), .cmd_out(cmd_out), .cmd_oe(cmd_oe), .dat_out(dat_out), .dat_oe(dat_oe),
    .link_clk(link_clk), .cmd_line(cmd_line), .dat_line(dat_line));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [63:0] resp(input logic [5:0] idx, input logic [31:0] p);
    return {16'h0000, 2'b00, idx, p, h.crc7({2'b00, idx, p}), 1'b1};
  endfunction

  task automatic cmd(input logic [5:0] idx, input logic good, input logic [63:0] exp);
    cq.push_back(exp);
    h.send_cmd(idx, $urandom, good);
    fork
      h.tick(64);
      h.rx(1'b0, 48);
    join
  endtask

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // about 0.7 ms of traffic expected
  initial
  begin
    #4ms;
    mismatches++;
    complete_run();
  end

  initial
    forever
    begin
      @(h.got_c);
      check(h.rcv, cq.pop_front());
    end

  initial
    forever
    begin
      @(h.got_d);
      check(h.rdv, dq.pop_front());
    end

  always @(negedge clock)
  begin
    if (wr_valid === 1'b1)
      check({56'h0, wr_data}, wq.pop_front());
    if (wr_done === 1'b1)
      check({63'h0, wr_crc_ok}, wq.pop_front());
    if (rd_take === 1'b1)
    begin
      ri <= ri + 1;
      rd_data <= rb[(ri + 1) % NB];
    end
  end

  initial
  begin
    logic [31:0] blk;
    void'($urandom(66509));
    nrst = 1'b0;
    rd_data = 8'h00;
    mismatches = 0;
    samples_checked = 0;
    ri = 0;
    repeat (5) @(negedge clock);
    check({62'h0, init_done, cmd_oe}, 64'h0);
    nrst = 1'b1;
    h.ones(63);
    check({63'h0, init_done}, 64'h0);
    h.ones(1);
    repeat (2) @(negedge clock);
    check({63'h0, init_done}, 64'h1);
    h.ones(10);
    cmd(CMD_READ_BLOCK, 1'b1, NONE);
    $display("init and idle test done");
    // keep polling while busy
    cmd(CMD_OP_COND, 1'b1, resp(CMD_OP_COND, {1'b1, 7'h00, VP}));
    cmd(CMD_OP_COND, 1'b1, resp(CMD_OP_COND, {1'b1, 7'h00, VP}));
    check({63'h0, card_active}, 64'h0);
    cmd(CMD_OP_COND, 1'b1, resp(CMD_OP_COND, {8'h00, VP}));
    check({63'h0, card_active}, 64'h1);
    // eight idle link clocks before the next command
    h.tick(8);
    $display("power-up test done");
    cmd(6'h0D, 1'b0, NONE);
    // the host repeats the command that failed
    cmd(6'h0D, 1'b1, resp(6'h0D, 32'h0000000C));
    cmd(6'h0D, 1'b1, resp(6'h0D, 32'h00000004));
    $display("command checksum test done");
    foreach (rb[i])
      rb[i] = 8'($urandom);
    blk = {rb[0], rb[1], rb[2], rb[3]};
    ri = 0;
    rd_data = rb[0];
    cq.push_back(resp(CMD_READ_BLOCK, 32'h0));
    dq.push_back({14'h0, 1'b0, blk, h.crc16(blk), 1'b1});
    h.send_cmd(CMD_READ_BLOCK, $urandom, 1'b1);
    fork
      h.tick(120);
      h.rx(1'b0, 48);
      h.rx(1'b1, 50);
    join
    $display("read block test done");
    for (int b = 0; b < 2; b++)
    begin
      blk = $urandom;
      for (int i = 3; i >= 0; i--)
        wq.push_back({56'h0, blk[i*8 +: 8]});
      wq.push_back({63'h0, b == 0});
      cmd(CMD_WRITE_BLOCK, 1'b1, resp(CMD_WRITE_BLOCK, 32'h0));
      dq.push_back({59'h0, 1'b0, (b == 0) ? DR_ACCEPT : DR_CRC_REJECT, 1'b1});
      h.send(1'b1, {14'h0, 1'b0, blk, h.crc16(blk) ^ {15'h0, b == 1}, 1'b1}, 50);
      fork
        h.tick(30);
        h.rx(1'b1, 5);
      join
    end
    $display("write block test done");
    cmd(CMD_RESET, 1'b1, NONE);
    check({63'h0, card_active}, 64'h0);
    cmd(6'h0D, 1'b1, NONE);
    cmd(CMD_OP_COND, 1'b1, resp(CMD_OP_COND, {8'h00, VP}));
    $display("software reset test done");
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    check({62'h0, init_done, card_active}, 64'h0);
    $display("power reset test done");
    complete_run();
  end
endmodule

// [hw/card_link_core.sv]
// card side of the serial card bus: command/response and data checksums,
// power-up init sequence, busy polling and software reset
// assumes link clock, command and data pins arrive asynchronously; user
// byte ports run on the core clock
//
// Overview of operation
// - command/response frames carry 7-bit checksum, x^7+x^3+1
// - card checks checksum of every received command
// - card appends checksum to every response frame
// - data blocks carry 16-bit checksum, x^16+x^12+x^5+1
// - sent data block followed immediately by its checksum
// - both ends generate and check both checksums
// - on-card power detection gives initial state
// - reset command returns card to idle state
// - idle card ignores everything until operating-conditions command
// - busy flag set until power-up procedure finishes
// - card ready after 64 clocks of ones
// - previous command checksum failure flagged in status
// - bad written block answered with rejection token
`timescale 1ns/1ps
module card_link_core
  import card_link_pkg::*;
#(
  parameter int          BLOCK_BYTES    = 512,
  parameter int          POWERUP_CYCLES = 4000,
  parameter logic [23:0] VOLT_PROFILE   = 24'hFF8000
)(
  // core clock and power-detect reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // card bus pins
  input  wire logic       link_clk,
  input  wire logic       cmd_in,
  output logic            cmd_out,
  output logic            cmd_oe,
  input  wire logic       dat_in,
  output logic            dat_out,
  output logic            dat_oe,
  // read block source
  input  wire logic [7:0] rd_data,
  output logic            rd_take,
  // written block sink
  output logic [7:0]      wr_data,
  output logic            wr_valid,
  output logic            wr_done,
  output logic            wr_crc_ok,
  // card state
  output logic            init_done,
  output logic            card_active
);

  if (BLOCK_BYTES < 1 || BLOCK_BYTES > MAX_BLOCK_BYTES || POWERUP_CYCLES < 1 || POWERUP_CYCLES > 65535)
  begin : g_check
    $error("card_link_core: unsupported parameter value");
  end

  localparam logic [14:0] N_BITS   = 15'(BLOCK_BYTES * 8);
  localparam logic [14:0] GAP_K    = 15'(DATA_GAP);
  localparam logic [14:0] TX_FIRST = 15'(DATA_GAP + 1);
  localparam logic [14:0] TX_CRC   = TX_FIRST + N_BITS;
  localparam logic [14:0] TX_END   = TX_CRC + 15'(CRC16_BITS);
  localparam logic [14:0] RX_CRC   = 15'(1) + N_BITS;
  localparam logic [14:0] RX_END   = RX_CRC + 15'(CRC16_BITS);
  localparam logic [14:0] TOK_END  = 15'(DATA_GAP + TOKEN_BITS);
  localparam logic [15:0] PU_DONE  = 16'(POWERUP_CYCLES);
  localparam logic [6:0]  ONES_END = 7'(INIT_ONES - 1);
  localparam logic [6:0]  SEND_LEN = 7'(FRAME_BITS + RESP_GAP);

  function automatic logic [6:0] crc7_next(input logic [6:0] crc, input logic b);
    crc7_next = {crc[5:0], 1'h0} ^ ((b ^ crc[6]) ? CRC7_POLY : 7'h00);
  endfunction

  function automatic logic [15:0] crc16_next(input logic [15:0] crc, input logic b);
    crc16_next = {crc[14:0], 1'h0} ^ ((b ^ crc[15]) ? CRC16_POLY : 16'h0000);
  endfunction

  function automatic logic [6:0] crc7_frame(input logic [39:0] hdr);
    logic [6:0] crc;
    crc = 7'h00;
    for (int i = HDR_BITS - 1; i >= 0; i--)
      crc = crc7_next(crc, hdr[i]);
    crc7_frame = crc;
  endfunction

  // pin synchronisers; link clock edges come from stages 1 and 2
  logic [2:0] clk_sync;
  logic [1:0] cmd_sync;
  logic [1:0] dat_sync;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      // link clock idles high: a zero here would fake a rise after release
      clk_sync <= 3'h7;
      cmd_sync <= 2'h3;
      dat_sync <= 2'h3;
    end
    else
    begin
      clk_sync <= {clk_sync[1:0], link_clk};
      cmd_sync <= {cmd_sync[0], cmd_in};
      dat_sync <= {dat_sync[0], dat_in};
    end
  end

  logic link_rise;
  logic link_fall;
  logic cmd_bit;
  logic dat_s_bit;
  assign link_rise = clk_sync[1] & ~clk_sync[2];
  assign link_fall = ~clk_sync[1] & clk_sync[2];
  assign cmd_bit   = cmd_sync[1];
  assign dat_s_bit = dat_sync[1];

  cmd_s   c;
  cmd_s   next_c;
  dat_s   d;
  dat_s   next_d;
  phase_e ph;
  phase_e next_ph;
  logic [6:0]  ones;
  logic [6:0]  next_ones;
  logic [15:0] pu_cnt;
  logic [15:0] next_pu_cnt;

  // decode of a fully received command
  logic [5:0] idx;
  logic       ev;
  logic       ev_good;
  logic       pu_done;
  assign idx     = c.sh[POS_IDX_LO +: 6];
  assign ev      = (c.st == C_EVAL);
  assign ev_good = ev && (c.crc == c.sh[POS_CRC_LO +: 7]) && c.sh[0] && c.sh[POS_DIR];
  assign pu_done = (pu_cnt == PU_DONE);

  // power-up phase
  always_comb
  begin
    next_ph     = ph;
    next_ones   = ones;
    next_pu_cnt = pu_cnt;
    if (pu_cnt != 16'h0000 && !pu_done)
      next_pu_cnt = pu_cnt + 16'h0001;
    unique case (ph)
      PH_INIT:
      begin
        if (link_rise)
        begin
          next_ones = cmd_bit ? ones + 7'h01 : 7'h00;
          if (cmd_bit && ones == ONES_END)
            next_ph = PH_IDLE;
        end
      end
      PH_IDLE:
      begin
        if (ev_good && idx == CMD_OP_COND)
        begin
          if (pu_cnt == 16'h0000)
            next_pu_cnt = 16'h0001;
          if (pu_done)
            next_ph = PH_ACTIVE;
        end
      end
      PH_ACTIVE:
      begin
        if (ev_good && idx == CMD_RESET)
          next_ph = PH_IDLE;
      end
      default: next_ph = PH_INIT;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ph     <= PH_INIT;
      ones   <= 7'h00;
      pu_cnt <= 16'h0000;
    end
    else
    begin
      ph     <= next_ph;
      ones   <= next_ones;
      pu_cnt <= next_pu_cnt;
    end
  end

  // command receive, check and response
  logic        respond;
  logic [31:0] payload;
  logic [39:0] hdr;
  logic [7:0]  stat;
  always_comb
  begin
    next_c  = c;
    stat    = 8'h00;
    stat[STAT_IDLE_BIT]    = (ph != PH_ACTIVE);
    stat[STAT_ILLEGAL_BIT] = !(idx == CMD_OP_COND || idx == CMD_READ_BLOCK || idx == CMD_WRITE_BLOCK);
    stat[STAT_CRC_ERR_BIT] = c.crc_err;
    payload = {8'h00, VOLT_PROFILE};
    payload[OCR_BUSY_BIT] = !pu_done;
    if (idx != CMD_OP_COND)
      payload = {24'h000000, stat};
    hdr     = {1'h0, 1'h0, idx, payload};
    respond = (ph == PH_ACTIVE) || (ph == PH_IDLE && idx == CMD_OP_COND);
    unique case (c.st)
      C_WAIT:
      begin
        if (link_rise && !cmd_bit && ph != PH_INIT)
        begin
          next_c.st  = C_RECV;
          next_c.sh  = 48'h0;
          next_c.cnt = 7'h01;
          next_c.crc = crc7_next(7'h00, 1'h0);
        end
      end
      C_RECV:
      begin
        if (link_rise)
        begin
          next_c.sh  = {c.sh[46:0], cmd_bit};
          next_c.cnt = c.cnt + 7'h01;
          if (c.cnt < 7'(HDR_BITS))
            next_c.crc = crc7_next(c.crc, cmd_bit);
          if (c.cnt == 7'(FRAME_BITS - 1))
            next_c.st = C_EVAL;
        end
      end
      C_EVAL:
      begin
        next_c.st = C_WAIT;
        if (!ev_good)
          next_c.crc_err = 1'h1;
        else if (idx == CMD_RESET)
          next_c.crc_err = 1'h0;
        else if (respond)
        begin
          next_c.sh      = {hdr, crc7_frame(hdr), 1'h1};
          next_c.cnt     = SEND_LEN;
          next_c.st      = C_SEND;
          next_c.crc_err = 1'h0;
        end
      end
      C_SEND:
      begin
        if (link_fall)
        begin
          next_c.cnt = c.cnt - 7'h01;
          if (c.cnt == 7'h00)
          begin
            next_c.oe = 1'h0;
            next_c.st = C_WAIT;
          end
          else if (c.cnt <= 7'(FRAME_BITS))
          begin
            next_c.out = c.sh[FRAME_BITS - 1];
            next_c.oe  = 1'h1;
            next_c.sh  = {c.sh[46:0], 1'h1};
          end
        end
      end
      default: next_c.st = C_WAIT;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      c <= '{st: C_WAIT, out: 1'h1, default: '0};
    else
      c <= next_c;
  end

  // data line: block send, block receive, response token
  always_comb
  begin
    next_d        = d;
    next_d.take   = 1'h0;
    next_d.wvalid = 1'h0;
    next_d.wdone  = 1'h0;
    unique case (d.st)
      D_OFF:
      begin
        next_d.oe = 1'h0;
        next_d.k  = 15'h0000;
        if (ev_good && ph == PH_ACTIVE && idx == CMD_READ_BLOCK)
          next_d.st = D_TX;
        else if (ev_good && ph == PH_ACTIVE && idx == CMD_WRITE_BLOCK)
          next_d.st = D_RXWAIT;
      end
      D_RXWAIT:
      begin
        if (link_rise && !dat_s_bit)
        begin
          next_d.st  = D_RX;
          next_d.k   = 15'h0001;
          next_d.crc = 16'h0000;
          next_d.bad = 1'h0;
        end
      end
      D_RX:
      begin
        if (link_rise)
        begin
          next_d.k = d.k + 15'h0001;
          if (d.k < RX_CRC)
          begin
            next_d.sh  = {d.sh[6:0], dat_s_bit};
            next_d.crc = crc16_next(d.crc, dat_s_bit);
            if (d.k[2:0] == 3'h0)
            begin
              next_d.wdata  = {d.sh[6:0], dat_s_bit};
              next_d.wvalid = 1'h1;
            end
          end
          else if (d.k < RX_END)
          begin
            if (dat_s_bit != d.crc[15])
              next_d.bad = 1'h1;
            next_d.crc = {d.crc[14:0], 1'h0};
          end
          else
          begin
            next_d.st    = D_TOK;
            next_d.k     = 15'h0000;
            next_d.wdone = 1'h1;
            next_d.wok   = !d.bad && dat_s_bit;
            next_d.sh    = {1'h0, (d.bad || !dat_s_bit) ? DR_CRC_REJECT : DR_ACCEPT, 1'h1, 3'h0};
          end
        end
      end
      D_TOK:
      begin
        if (link_fall)
        begin
          next_d.k = d.k + 15'h0001;
          if (d.k >= TOK_END)
          begin
            next_d.oe = 1'h0;
            next_d.st = D_OFF;
          end
          else if (d.k >= GAP_K)
          begin
            next_d.out = d.sh[7];
            next_d.oe  = 1'h1;
            next_d.sh  = {d.sh[6:0], 1'h1};
          end
        end
      end
      D_TX:
      begin
        if (link_fall)
        begin
          next_d.k = d.k + 15'h0001;
          if (d.k < GAP_K)
            next_d.oe = 1'h0;
          else if (d.k == GAP_K)
          begin
            next_d.out = 1'h0;
            next_d.oe  = 1'h1;
            next_d.crc = 16'h0000;
          end
          else if (d.k < TX_CRC)
          begin
            if (((d.k - TX_FIRST) & 15'h0007) == 15'h0000)
            begin
              next_d.out  = rd_data[7];
              next_d.sh   = {rd_data[6:0], 1'h0};
              next_d.take = 1'h1;
              next_d.crc  = crc16_next(d.crc, rd_data[7]);
            end
            else
            begin
              next_d.out = d.sh[7];
              next_d.sh  = {d.sh[6:0], 1'h0};
              next_d.crc = crc16_next(d.crc, d.sh[7]);
            end
          end
          else if (d.k < TX_END)
          begin
            next_d.out = d.crc[15];
            next_d.crc = {d.crc[14:0], 1'h0};
          end
          else if (d.k == TX_END)
            next_d.out = 1'h1;
          else
          begin
            next_d.oe = 1'h0;
            next_d.st = D_OFF;
          end
        end
      end
      default: next_d.st = D_OFF;
    endcase
    if (ev_good && idx == CMD_RESET)
    begin
      next_d.st = D_OFF;
      next_d.oe = 1'h0;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      d <= '{st: D_OFF, out: 1'h1, default: '0};
    else
      d <= next_d;
  end

  assign cmd_out     = c.out;
  assign cmd_oe      = c.oe;
  assign dat_out     = d.out;
  assign dat_oe      = d.oe;
  assign rd_take     = d.take;
  assign wr_data     = d.wdata;
  assign wr_valid    = d.wvalid;
  assign wr_done     = d.wdone;
  assign wr_crc_ok   = d.wok;
  assign init_done   = (ph != PH_INIT);
  assign card_active = (ph == PH_ACTIVE);

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  a_init_ones_count: assert property (ph == PH_INIT && next_ph == PH_IDLE |-> ones == ONES_END && cmd_bit)
    else $error("init left before 64 ones");
  a_bad_crc_silent: assert property (ev && !ev_good |=> c.st == C_WAIT && c.crc_err && !c.oe)
    else $error("bad command not dropped");
  a_idle_ignores: assert property (ev && ph == PH_IDLE && idx != CMD_OP_COND |=> c.st == C_WAIT [*2])
    else $error("idle card answered a command");
  a_reset_to_idle: assert property (ev_good && idx == CMD_RESET && ph != PH_INIT |=> ph == PH_IDLE && d.st == D_OFF)
    else $error("reset command ignored");
  a_resp_checksum: assert property ($rose(c.st == C_SEND) |-> c.sh[POS_CRC_LO +: 7] == crc7_frame(c.sh[47:8]))
    else $error("response checksum wrong");
  a_busy_flag: assert property (ev_good && respond && idx == CMD_OP_COND
    |=> c.sh[POS_ARG_LO + OCR_BUSY_BIT] == !$past(pu_done))
    else $error("busy flag mismatch");
  a_crc_err_report: assert property (ev_good && respond && idx != CMD_OP_COND && idx != CMD_RESET && c.crc_err
    |=> c.sh[POS_ARG_LO + STAT_CRC_ERR_BIT])
    else $error("checksum error not reported");
  a_data_crc_follows: assert property (d.st == D_TX && link_fall && d.k == TX_CRC |=> d.out == $past(d.crc[15]))
    else $error("data checksum not sent next");
  a_reject_token: assert property (d.st == D_RX && link_rise && d.k >= RX_END && d.bad
    |=> d.sh[6:4] == DR_CRC_REJECT && !d.wok)
    else $error("bad block not rejected");
  a_resp_bounded: assert property ($rose(c.st == C_SEND) |-> ##[1:1000] c.oe)
    else $error("response never driven");

endmodule

// [hw/card_link_pkg.sv]
// constants, states and carrier structs for the card-side link checker
// assumes one 20 MHz core clock; the link clock is sampled as plain data
package card_link_pkg;

  // power-up handshake
  localparam int INIT_ONES     = 64;  // ones after which the card listens
  localparam int SYNC_MARGIN   = 10;  // extra ones the host adds, not counted
  localparam int RESP_GAP      = 2;   // link clocks between command end and response
  localparam int DATA_GAP      = 2;   // link clocks before a data block or token
  localparam int MAX_BLOCK_BYTES = 2048;

  // command indices
  localparam logic [5:0] CMD_RESET       = 6'h00;
  localparam logic [5:0] CMD_OP_COND     = 6'h01;
  localparam logic [5:0] CMD_READ_BLOCK  = 6'h11;
  localparam logic [5:0] CMD_WRITE_BLOCK = 6'h18;

  // 48-bit command and response frame layout
  localparam int FRAME_BITS = 48;
  localparam int HDR_BITS   = 40;
  localparam int POS_DIR    = 46;
  localparam int POS_IDX_LO = 40;
  localparam int POS_ARG_LO = 8;
  localparam int POS_CRC_LO = 1;

  // checksum generators, leading term implied
  localparam logic [6:0]  CRC7_POLY  = 7'h09;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam int CRC16_BITS = 16;

  // response payload fields
  localparam int OCR_BUSY_BIT     = 31;
  localparam int STAT_IDLE_BIT    = 0;
  localparam int STAT_ILLEGAL_BIT = 2;
  localparam int STAT_CRC_ERR_BIT = 3;

  // data response token: start, three status bits, end
  localparam logic [2:0] DR_ACCEPT     = 3'h2;
  localparam logic [2:0] DR_CRC_REJECT = 3'h5;
  localparam int TOKEN_BITS = 5;

  typedef enum logic [2:0] {
    PH_INIT   = 3'h1,
    PH_IDLE   = 3'h2,
    PH_ACTIVE = 3'h4
  } phase_e;

  typedef enum logic [3:0] {
    C_WAIT = 4'h1,
    C_RECV = 4'h2,
    C_EVAL = 4'h4,
    C_SEND = 4'h8
  } cmd_e;

  typedef enum logic [4:0] {
    D_OFF    = 5'h01,
    D_RXWAIT = 5'h02,
    D_RX     = 5'h04,
    D_TOK    = 5'h08,
    D_TX     = 5'h10
  } dat_e;

  typedef struct packed {
    cmd_e        st;
    logic [6:0]  cnt;
    logic [47:0] sh;
    logic [6:0]  crc;
    logic        crc_err;
    logic        out;
    logic        oe;
  } cmd_s;

  typedef struct packed {
    dat_e        st;
    logic [14:0] k;
    logic [7:0]  sh;
    logic [15:0] crc;
    logic        bad;
    logic        out;
    logic        oe;
    logic        take;
    logic [7:0]  wdata;
    logic        wvalid;
    logic        wdone;
    logic        wok;
  } dat_s;

endpackage
